// >>> mqs_cfg.svh
// constants for the multi-queue standard port switch
`ifndef MQS_CFG_SVH
`define MQS_CFG_SVH
`define MQS_QNUM        128
`define MQS_QIDX_W      7
`define MQS_QDEPTH      16
`define MQS_PTR_W       4
`define MQS_OCC_W       5
`define MQS_DATA_W      36
`define MQS_ADDR_W      8
`define MQS_GRP_W       4
`define MQS_AF_OFFSET   5'h04
`define MQS_AE_OFFSET   5'h04
`define MQS_REG_CTRL    12'h000
`define MQS_REG_STATUS  12'h004
`define MQS_CTRL_RST    32'h0000_0000
`define MQS_CTRL_ID_BIT 0
`define MQS_ST_WQ_LSB   0
`define MQS_ST_RQ_LSB   8
`define MQS_ST_FULL_BIT 16
`define MQS_ST_EMPT_BIT 17
`define MQS_ST_WSW_LSB  20
`define MQS_ST_RSW_LSB  24
`endif

// >>> mqs_pkg.sv
// types shared by the multi-queue standard port switch
package mqs_pkg;
    typedef enum logic [1:0] {
        SW_IDLE,
        SW_ONE,
        SW_TWO,
        SW_THREE
    } mqs_sw_t;

    typedef struct packed {
        logic [35:0] data;
        logic        en_n;
        logic [7:0]  addr;
        logic        addr_strobe;
        logic        flag_strobe;
    } mqs_wr_req_t;

    typedef struct packed {
        logic        en_n;
        logic [7:0]  addr;
        logic        addr_strobe;
        logic        flag_strobe;
        logic        oe_n;
    } mqs_rd_req_t;
endpackage

// >>> mqs_port_switch.sv
// multi-queue standard mode queue switch, storage and flags with an apb register slave
//
// How it works
// - address strobe high at a clock edge captures the next write queue.
// - write queue switch takes four cycles; write enable plays no part.
// - accepted writes go to the selected queue until another is chosen.
// - a write word can be taken on every edge, also during selection.
// - select edge and two after write the old queue when enabled.
// - full flag shows the new queue from the third switch edge.
// - first word into the new queue is taken at the fourth edge.
// - writes into a full queue are blocked and change nothing.
// - address msb must match the chip code; low seven bits pick queue.
// - flag strobe with address strobe low picks eight almost-full flags.
// - read address strobe high captures the next read queue.
// - reads come from the selected queue until another is chosen.
// - a word can be read on every edge but the fourth of a selection.
// - read switch needs four cycles; first two read the old queue.
// - empty flag shows the new read queue from the third edge.
// - third edge loads the pipeline; new word reaches output next edge.
// - reads from an empty queue are blocked, read position held.
// - output enable only gates the bus; output register still loads.
// - read flag strobe picks eight almost-empty flags by low four bits.
// - empty flag is active low for the present read queue.
// - full flag is active low for the present write queue.
`include "mqs_cfg.svh"

module mqs_port_switch (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    clk_en,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire mqs_pkg::mqs_wr_req_t    wr_req,
    output logic                         queue_full_n,
    output logic      [7:0]              almost_full_bus_n,
    input  wire mqs_pkg::mqs_rd_req_t    rd_req,
    output logic      [35:0]             read_data,
    output logic                         read_data_oe,
    output logic                         queue_empty_n,
    output logic      [7:0]              almost_empty_bus_n
);
    import mqs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // storage: one flat array, each queue owns a fixed slice
    logic [`MQS_DATA_W-1:0] mem [`MQS_QNUM*`MQS_QDEPTH];
    logic [`MQS_PTR_W-1:0]  wptr_q [`MQS_QNUM];
    logic [`MQS_PTR_W-1:0]  rptr_q [`MQS_QNUM];
    logic [`MQS_OCC_W-1:0]  occ_q  [`MQS_QNUM];

    logic [31:0]             ctrl_q;
    logic                    chip_select_code_bit0;
    logic [`MQS_QIDX_W-1:0]  wq_cur_q;
    logic [`MQS_QIDX_W-1:0]  wq_next_q;
    logic [`MQS_QIDX_W-1:0]  rq_cur_q;
    logic [`MQS_QIDX_W-1:0]  rq_next_q;
    mqs_sw_t                 wsw_q;
    mqs_sw_t                 rsw_q;
    logic [`MQS_GRP_W-1:0]   af_grp_q;
    logic [`MQS_GRP_W-1:0]   ae_grp_q;
    logic [`MQS_DATA_W-1:0]  pf_q;
    logic                    pf_v_q;
    logic [`MQS_QIDX_W-1:0]  w_tgt;
    logic [`MQS_QIDX_W-1:0]  r_tgt;
    logic [`MQS_QIDX_W-1:0]  w_show;
    logic [`MQS_QIDX_W-1:0]  r_show;
    logic                    wsel;
    logic                    rsel;
    logic                    wr_fire;
    logic                    rd_fire;

    assign chip_select_code_bit0 = ctrl_q[`MQS_CTRL_ID_BIT];

    // occupancy of a queue once this edge's write and read have landed
    function automatic logic [`MQS_OCC_W-1:0] occ_after(input logic [`MQS_QIDX_W-1:0] q);
        logic [`MQS_OCC_W-1:0] v;
        v = occ_q[q];
        if (wr_fire && w_tgt == q) begin
            v = v + 5'h01;
        end
        if (rd_fire && r_tgt == q) begin
            v = v - 5'h01;
        end
        return v;
    endfunction

    // memory slot of a queue entry
    function automatic logic [10:0] slot(input logic [`MQS_QIDX_W-1:0] q,
                                         input logic [`MQS_PTR_W-1:0] p);
        return {q, p};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // write port
    assign wsel = wr_req.addr_strobe
                  && (wr_req.addr[`MQS_ADDR_W-1] == chip_select_code_bit0);
    // old queue until the fourth edge of a switch
    assign w_tgt = (wsw_q == SW_THREE) ? wq_next_q : wq_cur_q;
    // flag follows the new queue from the third edge on
    assign w_show = (wsw_q == SW_TWO || wsw_q == SW_THREE) ? wq_next_q : wq_cur_q;
    // enable and room in the target queue decide the write, never the address strobe
    assign wr_fire = !wr_req.en_n && (occ_q[w_tgt] != 5'(`MQS_QDEPTH));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wsw_q     <= SW_IDLE;
            wq_cur_q  <= 7'h00;
            wq_next_q <= 7'h00;
        end else if (clk_en) begin
            case (wsw_q)
                SW_IDLE: begin
                    if (wsel) begin
                        wq_next_q <= wr_req.addr[`MQS_QIDX_W-1:0];
                        wsw_q     <= SW_ONE;
                    end
                end
                SW_ONE: begin
                    wsw_q <= SW_TWO;
                end
                SW_TWO: begin
                    wsw_q <= SW_THREE;
                end
                SW_THREE: begin
                    wq_cur_q <= wq_next_q;
                    wsw_q    <= SW_IDLE;
                end
                default: begin
                    wsw_q <= SW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk) begin
        if (clk_en && wr_fire) begin
            mem[slot(w_tgt, wptr_q[w_tgt])] <= wr_req.data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            queue_full_n <= 1'b1;
        end else if (clk_en) begin
            queue_full_n <= (occ_after(w_show) != 5'(`MQS_QDEPTH));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            af_grp_q <= 4'h0;
        end else if (clk_en && !wr_req.addr_strobe && wr_req.flag_strobe) begin
            af_grp_q <= wr_req.addr[`MQS_GRP_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port
    assign rsel  = rd_req.addr_strobe
                   && (rd_req.addr[`MQS_ADDR_W-1] == chip_select_code_bit0);
    assign r_tgt = (rsw_q == SW_TWO) ? rq_next_q : rq_cur_q;
    assign r_show = (rsw_q == SW_TWO || rsw_q == SW_THREE) ? rq_next_q : rq_cur_q;
    // the prefetch at the third edge ignores the read enable
    always_comb begin
        case (rsw_q)
            SW_IDLE, SW_ONE: rd_fire = !rd_req.en_n && (occ_q[rq_cur_q] != 5'h00);
            SW_TWO:          rd_fire = (occ_q[rq_next_q] != 5'h00);
            default:         rd_fire = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsw_q     <= SW_IDLE;
            rq_cur_q  <= 7'h00;
            rq_next_q <= 7'h00;
        end else if (clk_en) begin
            case (rsw_q)
                SW_IDLE: begin
                    if (rsel) begin
                        rq_next_q <= rd_req.addr[`MQS_QIDX_W-1:0];
                        rsw_q     <= SW_ONE;
                    end
                end
                SW_ONE: begin
                    rsw_q <= SW_TWO;
                end
                SW_TWO: begin
                    rsw_q <= SW_THREE;
                end
                SW_THREE: begin
                    rq_cur_q <= rq_next_q;
                    rsw_q    <= SW_IDLE;
                end
                default: begin
                    rsw_q <= SW_IDLE;
                end
            endcase
        end
    end

    // output pipeline: at the third edge the old word stays in the output register
    // and the new queue's head sits in the prefetch stage, then moves on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_data <= 36'h0_0000_0000;
            pf_q      <= 36'h0_0000_0000;
            pf_v_q    <= 1'b0;
        end else if (clk_en) begin
            if (rsw_q == SW_TWO) begin
                pf_v_q <= rd_fire;
                if (rd_fire) begin
                    pf_q <= mem[slot(r_tgt, rptr_q[r_tgt])];
                end
            end else if (rsw_q == SW_THREE) begin
                pf_v_q <= 1'b0;
                if (pf_v_q) begin
                    read_data <= pf_q;
                end
            end else if (rd_fire) begin
                read_data <= mem[slot(r_tgt, rptr_q[r_tgt])];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_data_oe <= 1'b0;
        end else if (clk_en) begin
            read_data_oe <= !rd_req.oe_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            queue_empty_n <= 1'b0;
        end else if (clk_en) begin
            queue_empty_n <= (occ_after(r_show) != 5'h00);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ae_grp_q <= 4'h0;
        end else if (clk_en && !rd_req.addr_strobe && rd_req.flag_strobe) begin
            ae_grp_q <= rd_req.addr[`MQS_GRP_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointers and counts; one clock for both ports, so no crossing is needed
    genvar gq;
    generate
        for (gq = 0; gq < `MQS_QNUM; gq++) begin : g_queue
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    wptr_q[gq] <= 4'h0;
                    rptr_q[gq] <= 4'h0;
                    occ_q[gq]  <= 5'h00;
                end else if (clk_en) begin
                    if (wr_fire && w_tgt == 7'(gq)) begin
                        wptr_q[gq] <= wptr_q[gq] + 4'h1;
                    end
                    if (rd_fire && r_tgt == 7'(gq)) begin
                        rptr_q[gq] <= rptr_q[gq] + 4'h1;
                    end
                    occ_q[gq] <= occ_after(7'(gq));
                end
            end
        end
    endgenerate

    // flag buses, eight queues per group
    genvar gb;
    generate
        for (gb = 0; gb < 8; gb++) begin : g_flag_bus
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    almost_full_bus_n[gb]  <= 1'b1;
                    almost_empty_bus_n[gb] <= 1'b0;
                end else if (clk_en) begin
                    almost_full_bus_n[gb] <= occ_q[{af_grp_q, 3'(gb)}]
                        < 5'(`MQS_QDEPTH) - `MQS_AF_OFFSET;
                    almost_empty_bus_n[gb] <= occ_q[{ae_grp_q, 3'(gb)}]
                        > `MQS_AE_OFFSET;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, unmapped offsets answer with an error
    logic acc;
    logic mapped;
    assign acc    = psel && penable;
    assign mapped = (paddr == `MQS_REG_CTRL) || (paddr == `MQS_REG_STATUS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `MQS_CTRL_RST;
        end else if (clk_en && acc && pready && pwrite && paddr == `MQS_REG_CTRL) begin
            // committed at the access edge that carries the answer, never at setup
            // only the chip code bit is kept, the rest reads as zero
            ctrl_q <= {31'h0, pwdata[`MQS_CTRL_ID_BIT]};
        end
    end

    // answer is set up during the setup cycle so pready is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite && paddr == `MQS_REG_CTRL) begin
                prdata <= ctrl_q;
            end else if (psel && !penable && !pwrite && paddr == `MQS_REG_STATUS) begin
                prdata[`MQS_ST_WQ_LSB +: 7]  <= wq_cur_q;
                prdata[`MQS_ST_RQ_LSB +: 7]  <= rq_cur_q;
                prdata[`MQS_ST_FULL_BIT]     <= queue_full_n;
                prdata[`MQS_ST_EMPT_BIT]     <= queue_empty_n;
                prdata[`MQS_ST_WSW_LSB +: 2] <= wsw_q;
                prdata[`MQS_ST_RSW_LSB +: 2] <= rsw_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_wr_sw;
        wsel && wsw_q == SW_IDLE && clk_en ##1 clk_en ##1 clk_en;
    endsequence

    sequence s_rd_sw;
        rsel && rsw_q == SW_IDLE && clk_en ##1 clk_en ##1 clk_en;
    endsequence

    a_wr_switch_len: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_sw |=> wsw_q == SW_THREE && w_tgt == wq_next_q)
        else $error("write switch did not reach its fourth edge");

    a_wr_old_queue: assert property (@(posedge pclk) disable iff (!presetn)
        (wsw_q == SW_ONE || wsw_q == SW_TWO) |-> w_tgt == wq_cur_q)
        else $error("write during switch left the old queue");

    a_wr_full_flag: assert property (@(posedge pclk) disable iff (!presetn)
        wsw_q == SW_THREE |-> queue_full_n == (occ_q[wq_next_q] != 5'(`MQS_QDEPTH)))
        else $error("full flag does not follow the new queue");

    a_wr_full_block: assert property (@(posedge pclk) disable iff (!presetn)
        wr_fire |-> occ_q[w_tgt] != 5'(`MQS_QDEPTH))
        else $error("write into a full queue");

    a_rd_switch_len: assert property (@(posedge pclk) disable iff (!presetn)
        s_rd_sw |=> rsw_q == SW_THREE ##1 (rq_cur_q == $past(rq_next_q) || !$past(clk_en)))
        else $error("read switch length wrong");

    a_rd_empty_block: assert property (@(posedge pclk) disable iff (!presetn)
        rd_fire |-> occ_q[r_tgt] != 5'h00)
        else $error("read from an empty queue");

    a_rd_prefetch: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && rsw_q == SW_TWO && occ_q[rq_next_q] != 5'h00
        |=> pf_v_q ##1 (!pf_v_q || !$past(clk_en)))
        else $error("new queue word not fetched at third edge");

    a_rd_empty_flag: assert property (@(posedge pclk) disable iff (!presetn)
        rsw_q == SW_THREE |-> queue_empty_n == (occ_q[rq_next_q] != 5'h00))
        else $error("empty flag does not follow the new queue");

    a_oe_follow: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> read_data_oe == !$past(rd_req.oe_n))
        else $error("output enable not tracking its input");
endmodule

// >>> mqs_host.sv
// host model driving the write and read ports of the queue switch
module mqs_host (
    output mqs_pkg::mqs_wr_req_t wr_req,
    output mqs_pkg::mqs_rd_req_t rd_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import mqs_pkg::*;

    initial begin
        wr_req = '0;
        wr_req.en_n = 1'b1;
        rd_req = '0;
        rd_req.en_n = 1'b1;
        rd_req.oe_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////
    // called at a rising edge; levels hold until the next call
    // idle data is inverted so a stale word never passes for a fresh one
    task automatic drive(input logic ws, input logic [7:0] wa, input logic wn,
                         input logic [35:0] wd, input logic wf, input logic rs,
                         input logic [7:0] ra, input logic rn, input logic rf,
                         input logic oe);
        wr_req.addr_strobe <= ws;
        wr_req.addr <= wa;
        wr_req.en_n <= wn;
        wr_req.data <= wn ? ~wr_req.data : wd;
        wr_req.flag_strobe <= wf & ~ws;
        rd_req.addr_strobe <= rs;
        rd_req.addr <= ra;
        rd_req.en_n <= rn;
        rd_req.flag_strobe <= rf & ~rs;
        rd_req.oe_n <= oe;
    endtask
endmodule

// >>> multiqueue_standard_port_switch_bench.sv
// self-checking bench for the multi-queue standard port switch
`include "mqs_cfg.svh"
module multiqueue_standard_port_switch_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mqs_pkg::*;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, queue_full_n, read_data_oe, queue_empty_n;
    logic [7:0]  almost_full_bus_n, almost_empty_bus_n;
    logic [35:0] read_data;
    mqs_wr_req_t wr_req;
    mqs_rd_req_t rd_req;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          seed = 7;
    logic [35:0] mdl [128][$];
    logic [6:0]  wq = 7'h0, wnq = 7'h0, rq = 7'h0, rnq = 7'h0;
    logic [1:0]  wsw = 2'h0, rsw = 2'h0;
    logic        chip = 1'b0, pfv = 1'b0, exp_oe = 1'b0, clk_en = 1'b1;
    logic [35:0] exp_rd = 36'h0, pf = 36'h0;
    logic [7:0]  exp_af = 8'hff, exp_ae = 8'h00;
    logic [3:0]  af_g = 4'h0, ae_g = 4'h0;

    always #10 pclk = ~pclk;

    mqs_port_switch u_dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wr_req(wr_req), .queue_full_n(queue_full_n),
        .almost_full_bus_n(almost_full_bus_n), .rd_req(rd_req), .read_data(read_data),
        .read_data_oe(read_data_oe), .queue_empty_n(queue_empty_n),
        .almost_empty_bus_n(almost_empty_bus_n)
    );

    mqs_host u_host (.wr_req(wr_req), .rd_req(rd_req));

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [35:0] seen, input logic [35:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic logic [7:0] grp_bus(input logic [3:0] g, input logic af);
        logic [7:0] b;
        for (int i = 0; i < 8; i++)
            b[i] = af ? (mdl[{g, 3'(i)}].size() < `MQS_QDEPTH - `MQS_AF_OFFSET)
                      : (mdl[{g, 3'(i)}].size() > `MQS_AE_OFFSET);
        return b;
    endfunction

    function automatic logic [31:0] status_exp();
        return {6'h0, rsw, 2'h0, wsw, 2'h0, mdl[rq].size() != 0,
                mdl[wq].size() != `MQS_QDEPTH, 1'b0, rq, 1'b0, wq};
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [31:0] exp_d, input logic exp_err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // wait as long as the answer takes; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        if (!wr) check(prdata, exp_d);
        check(pslverr, exp_err);
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so the next setup never re-raises psel in this time step
        @(posedge pclk);
    endtask

    // one port cycle: drive at this edge, check the last edge, model the next edge
    task automatic step(input logic ws, input logic [7:0] wa, input logic wn,
                        input logic wf, input logic rs, input logic [7:0] ra,
                        input logic rn, input logic rf, input logic oe);
        logic [35:0] wd;
        logic [1:0]  wp, rp;
        logic [6:0]  tgt;
        logic        wfull;
        wd = {4'($random(seed)), 32'($random(seed))};
        u_host.drive(ws, wa, wn, wd, wf, rs, ra, rn, rf, oe);
        @(negedge pclk);
        check(queue_full_n, mdl[wsw == 2'd3 ? wnq : wq].size() != `MQS_QDEPTH);
        check(queue_empty_n, mdl[rsw == 2'd3 ? rnq : rq].size() != 0);
        check(read_data, exp_rd);
        check(read_data_oe, exp_oe);
        check(almost_full_bus_n, exp_af);
        check(almost_empty_bus_n, exp_ae);
        @(posedge pclk);
        // flag buses show the group held before this edge, with counts before this edge
        exp_af = grp_bus(af_g, 1'b1);
        exp_ae = grp_bus(ae_g, 1'b0);
        if (wf && !ws) af_g = wa[3:0];
        if (rf && !rs) ae_g = ra[3:0];
        wp = wsw;
        tgt = (wp == 2'd3) ? wnq : wq;
        wfull = mdl[tgt].size() == `MQS_QDEPTH;
        rp = rsw;
        // new queue head leaves the queue at the third edge, shows at the fourth
        if (rp == 2'd2) begin
            pfv = mdl[rnq].size() > 0;
            if (pfv) pf = mdl[rnq].pop_front();
        end
        if (rp == 2'd3) begin
            rq = rnq;
            if (pfv) exp_rd = pf;
        end else if (rp != 2'd2 && !rn && mdl[rq].size() > 0) begin
            exp_rd = mdl[rq].pop_front();
        end
        if (rp == 2'd0 && rs && ra[7] == chip) rnq = ra[6:0];
        rsw = (rp == 2'd0) ? {1'b0, rs && ra[7] == chip} : rp + 2'd1;
        exp_oe = !oe;
        wq = tgt;
        if (!wn && !wfull) mdl[tgt].push_back(wd);
        if (wp == 2'd0 && ws && wa[7] == chip) wnq = wa[6:0];
        wsw = (wp == 2'd0) ? {1'b0, ws && wa[7] == chip} : wp + 2'd1;
    endtask

    task automatic idle(input int n);
        repeat (n) step(1'b0, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        int r;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        check({prdata, pready, pslverr}, 36'h0);
        check({queue_full_n, queue_empty_n, read_data_oe, almost_full_bus_n,
               almost_empty_bus_n}, {3'b100, 8'hff, 8'h00});
        check(read_data, 36'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `MQS_REG_CTRL, 32'h0, `MQS_CTRL_RST, 1'b0);
        apb(1'b1, `MQS_REG_CTRL, 32'h1, 32'h0, 1'b0);
        chip = 1'b1;
        apb(1'b0, `MQS_REG_CTRL, 32'h0, 32'h1, 1'b0);
        apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h00c, 32'hffff_ffff, 32'h0, 1'b1);
        // chip code 1: a strobe with address msb 0 is ignored
        for (int i = 0; i < 4; i++)
            step(i == 0, 8'h05, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0, 1'b1);
        idle(1);
        apb(1'b1, `MQS_REG_CTRL, 32'h0, 32'h0, 1'b0);
        chip = 1'b0;
        // back-to-back words across a switch, then overfill
        for (int i = 0; i < 20; i++)
            step(i == 0, 8'h05, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 12; i++)
            step(i % 4 == 0, (i < 4 || i >= 8) ? 8'h06 : 8'h05, i >= 11, 1'b0,
                 1'b0, 8'h00, 1'b1, 1'b0, 1'b1);
        idle(1);
        for (int g = 0; g < 16; g++)
            step(1'b0, 8'(g), 1'b1, 1'b1, 1'b0, 8'(g), 1'b1, 1'b1, 1'b1);
        idle(1);
        // read switches: reads in flight, strobe with reads off, empty target
        for (int i = 0; i < 30; i++) begin
            r = $random(seed);
            step(1'b0, 8'h00, 1'b1, 1'b0, i == 5 || i == 12 || i == 20 || i == 26,
                 i < 12 ? 8'h06 : i < 20 ? 8'h05 : i < 26 ? 8'h09 : 8'h00,
                 i >= 12 && i < 16, 1'b0, r[0]);
        end
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            step(wsw == 2'd0 && r[1:0] == 2'd0, {r[2], 4'h0, r[5:3]}, r[6], r[7],
                 1'b0, {4'h0, r[15:12]}, r[9], r[10], r[11]);
        end
        // clock enable low: a switch, a write, a read and oe must all leave no trace
        clk_en <= 1'b0;
        u_host.drive(1'b1, 8'h03, 1'b0, 36'h0_0000_0a5a, 1'b1, 1'b1, 8'h01, 1'b0, 1'b1, 1'b0);
        repeat (3) @(posedge pclk);
        clk_en <= 1'b1;
        idle(5);
        apb(1'b0, `MQS_REG_STATUS, 32'h0, status_exp(), 1'b0);
        idle(1);
        end_sim;
    end

    initial begin
        #100us;
        n_fail++;
        end_sim;
    end
endmodule
